/* File: logic/print_seq_pkg.sv */
package print_seq_pkg;
    // ========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] PERIOD_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h10;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h14;
    localparam logic [7:0] SRC0_OFS     = 8'h20;
    localparam logic [7:0] SRC3_OFS     = 8'h2c;
    // ========================================================
    // Field positions
    localparam int CTRL_DRIVE_BIT = 0;
    localparam int CTRL_MODE_BIT  = 1;
    localparam int CTRL_PACE_BIT  = 2;
    localparam int CTRL_BASE_LSB  = 4;
    localparam int ST_DONE_BIT    = 0;
    localparam int ST_BUSY_BIT    = 1;
    localparam int ST_DRIVE_BIT   = 2;
    localparam int ST_IDX_LSB     = 8;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ABORT_BIT  = 1;
    // ========================================================
    // Sizes and reset values
    localparam int          SRC_REGS      = 4;
    localparam logic [3:0]  FIXED_LAST    = 4'h7;
    localparam logic [3:0]  VAR_LAST      = 4'hf;
    localparam logic [7:0]  NULL_CHAR     = 8'h00;
    localparam logic [5:0]  CTRL_RST      = 6'h00;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    localparam logic [31:0] SRC_RST       = 32'h0000_0000;
    // ========================================================
    // Step pacing: default step time and its cycle count
    localparam int          CLK_MHZ       = 25;
    localparam int          STEP_TIME_US  = 10;
    localparam int          STEP_CYCLES   = STEP_TIME_US * CLK_MHZ;
    localparam logic [15:0] PERIOD_RST    = 16'(STEP_CYCLES - 1);
    // ========================================================
    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
    // ========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_HOLD   = 4'b1000
    } seq_state_t;
endpackage : print_seq_pkg

/* File: logic/ascii_string_output_sequencer.sv */
// Function
// - Characters come in order from four source registers at the base.
// - Output takes ten points: eight data lines, then two control lines.
// - Data lines carry bit 0 first, then come strobe and execution flag.
// - Mode select clear sends eight characters while drive is held.
// - Fixed mode: drive drop aborts, clears all points; restart at char 0.
// - Mode select set sends strings of up to sixteen characters.
// - Variable mode ignores a drive drop and finishes the whole string.
// - Variable mode ends at a NULL code and sends nothing after it.
// - A done flag marks a finished string, low while drive stays held.
`timescale 1ns/1ps
`default_nettype none
module ascii_string_output_sequencer (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Drive contact pin
    input  wire logic        drive_contact_in,
    // Output points
    output logic      [7:0]  ascii_print_output_out,
    output logic             scan_strobe_point_out,
    output logic             execution_active_point_out,
    output logic             print_done_flag_out,
    output logic             irq_out
);
    // ========================================================
    // Reset release
    logic rst_s1_b_q;
    logic rst_b_q;
    always_ff @(posedge core_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_s1_b_q <= 1'b0;
            rst_b_q    <= 1'b0;
        end
        else
        begin
            rst_s1_b_q <= 1'b1;
            rst_b_q    <= rst_s1_b_q;
        end
    end

    // ========================================================
    // Drive pin synchroniser, taken once two stages agree
    logic drv_s1_q;
    logic drv_s2_q;
    logic drv_s3_q;
    logic drv_pin_q;
    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            drv_s1_q  <= 1'b0;
            drv_s2_q  <= 1'b0;
            drv_s3_q  <= 1'b0;
            drv_pin_q <= 1'b0;
        end
        else
        begin
            drv_s1_q <= drive_contact_in;
            drv_s2_q <= drv_s1_q;
            drv_s3_q <= drv_s2_q;
            if (drv_s2_q == drv_s3_q)
                drv_pin_q <= drv_s3_q;
        end
    end

    // ========================================================
    // Registers
    logic [5:0]  ctrl_q;
    logic [15:0] period_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_en_q;
    logic [31:0] src_q [print_seq_pkg::SRC_REGS];
    logic        done_q;
    logic [3:0]  idx_q;
    print_seq_pkg::seq_state_t state_q;

    wire drive    = drv_pin_q | ctrl_q[print_seq_pkg::CTRL_DRIVE_BIT];
    wire mode_sel = ctrl_q[print_seq_pkg::CTRL_MODE_BIT];
    wire pace_en  = ctrl_q[print_seq_pkg::CTRL_PACE_BIT];
    wire [1:0] src_base = ctrl_q[print_seq_pkg::CTRL_BASE_LSB +: 2];

    // ========================================================
    // AHB-Lite address and data phases
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    wire addr_ok   = hsel_in & hready_in & htrans_in[1];
    wire wr_take   = addr_ok & hwrite_in;
    wire rd_take   = addr_ok & ~hwrite_in;
    wire [7:0] ra  = haddr_in[7:0];
    wire src_hit_w = (wr_addr_q >= print_seq_pkg::SRC0_OFS)
                   & (wr_addr_q <= print_seq_pkg::SRC3_OFS);
    wire [1:0] src_w_sel = wr_addr_q[3:2];
    wire wr_ctrl   = wr_pend_q & (wr_addr_q == print_seq_pkg::CTRL_OFS);
    wire wr_period = wr_pend_q & (wr_addr_q == print_seq_pkg::PERIOD_OFS);
    wire wr_clr    = wr_pend_q & (wr_addr_q == print_seq_pkg::IRQ_CLR_OFS);
    wire wr_en     = wr_pend_q & (wr_addr_q == print_seq_pkg::IRQ_EN_OFS);
    wire wr_src    = wr_pend_q & src_hit_w;

    wire src_hit_r = (ra >= print_seq_pkg::SRC0_OFS)
                   & (ra <= print_seq_pkg::SRC3_OFS);
    wire [31:0] status_word = {16'h0000, 4'h0, idx_q, 5'h00,
                               drive, ~state_q[0], done_q};
    wire [31:0] rd_word =
        (ra == print_seq_pkg::CTRL_OFS)     ? {26'h0, ctrl_q}     :
        (ra == print_seq_pkg::PERIOD_OFS)   ? {16'h0, period_q}   :
        (ra == print_seq_pkg::STATUS_OFS)   ? status_word         :
        (ra == print_seq_pkg::IRQ_STAT_OFS) ? {30'h0, irq_stat_q} :
        (ra == print_seq_pkg::IRQ_EN_OFS)   ? {30'h0, irq_en_q}   :
        src_hit_r                           ? src_q[ra[3:2]]      :
                                              32'h0000_0000;
    // Write-only and unmapped addresses read as zero

    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            wr_pend_q     <= 1'b0;
            wr_addr_q     <= 8'h00;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
        else
        begin
            wr_pend_q <= wr_take;
            if (wr_take)
                wr_addr_q <= ra;
            if (rd_take)
                hrdata_out <= rd_word;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            ctrl_q   <= print_seq_pkg::CTRL_RST;
            period_q <= print_seq_pkg::PERIOD_RST;
            irq_en_q <= print_seq_pkg::IRQ_RST;
            for (int i = 0; i < print_seq_pkg::SRC_REGS; i++)
                src_q[i] <= print_seq_pkg::SRC_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= hwdata_in[5:0];
            if (wr_period)
                period_q <= hwdata_in[15:0];
            if (wr_en)
                irq_en_q <= hwdata_in[1:0];
            if (wr_src)
                src_q[src_w_sel] <= hwdata_in;
        end
    end

    // ========================================================
    // Step pacing timer; one step per period
    // With pacing off nothing advances; enabling it ticks at once
    logic [15:0] tick_cnt_q;
    logic        tick_q;
    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end
        else if (!pace_en)
        begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q <= (tick_cnt_q == 16'h0000);
            if (tick_cnt_q == 16'h0000)
                tick_cnt_q <= period_q;
            else
                tick_cnt_q <= tick_cnt_q - 16'h0001;
        end
    end

    // ========================================================
    // Character selection
    logic        mode_q;
    wire  [1:0]  src_sel  = src_base + idx_q[3:2];
    wire  [31:0] src_word = src_q[src_sel];
    wire  [7:0]  cur_char = src_word[{idx_q[1:0], 3'b000} +: 8];
    wire  [3:0]  last_idx = mode_q ? print_seq_pkg::VAR_LAST
                                   : print_seq_pkg::FIXED_LAST;
    wire is_null  = mode_q & (cur_char == print_seq_pkg::NULL_CHAR);
    wire busy     = state_q[1] | state_q[2];
    wire abort    = busy & ~mode_q & ~drive;
    wire null_end = state_q[1] & tick_q & is_null;
    wire last_end = state_q[2] & tick_q & (idx_q == last_idx);
    wire finish   = ~abort & (null_end | last_end);
    wire start    = state_q[0] & drive;
    wire hold_end = state_q[3] & ~drive;
    wire done_ev  = (finish & ~drive) | hold_end;

    // ========================================================
    // Next character, loaded as the strobe falls so that data never
    // moves under the strobe, however short the step
    wire  [3:0]  nxt_idx    = idx_q + 4'h1;
    wire  [1:0]  nxt_sel    = src_base + nxt_idx[3:2];
    wire  [31:0] nxt_word   = src_q[nxt_sel];
    wire  [7:0]  nxt_char   = nxt_word[{nxt_idx[1:0], 3'b000} +: 8];
    wire  [31:0] base_word  = src_q[src_base];
    wire  [7:0]  first_char = base_word[7:0];

    // ========================================================
    // Sequencer
    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            state_q <= print_seq_pkg::ST_IDLE;
            idx_q   <= 4'h0;
            mode_q  <= 1'b0;
        end
        else if (abort)
        begin
            state_q <= print_seq_pkg::ST_IDLE;
            idx_q   <= 4'h0;
        end
        else
        begin
            case (state_q)
                print_seq_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        idx_q   <= 4'h0;
                        mode_q  <= mode_sel;
                        state_q <= print_seq_pkg::ST_SETUP;
                    end
                end
                print_seq_pkg::ST_SETUP:
                begin
                    if (null_end)
                        state_q <= drive ? print_seq_pkg::ST_HOLD
                                         : print_seq_pkg::ST_IDLE;
                    else if (tick_q)
                        state_q <= print_seq_pkg::ST_STROBE;
                end
                print_seq_pkg::ST_STROBE:
                begin
                    if (last_end)
                        state_q <= drive ? print_seq_pkg::ST_HOLD
                                         : print_seq_pkg::ST_IDLE;
                    else if (tick_q)
                    begin
                        idx_q   <= nxt_idx;
                        state_q <= print_seq_pkg::ST_SETUP;
                    end
                end
                print_seq_pkg::ST_HOLD:
                begin
                    // Held drive after a string must not retrigger it
                    if (hold_end)
                        state_q <= print_seq_pkg::ST_IDLE;
                end
                default:
                    state_q <= print_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // ========================================================
    // Output points, all from flip-flops
    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            ascii_print_output_out     <= 8'h00;
            scan_strobe_point_out      <= 1'b0;
            execution_active_point_out <= 1'b0;
        end
        else if (abort | finish)
        begin
            ascii_print_output_out     <= 8'h00;
            scan_strobe_point_out      <= 1'b0;
            execution_active_point_out <= 1'b0;
        end
        else
        begin
            // First character goes out together with the execution flag
            if (start)
                ascii_print_output_out <= first_char;
            else if (state_q[2] & tick_q)
                ascii_print_output_out <= nxt_char;
            else if (state_q[0] | state_q[3])
                ascii_print_output_out <= 8'h00;
            scan_strobe_point_out      <= state_q[1] & tick_q
                                        | state_q[2] & ~tick_q;
            execution_active_point_out <= start | busy;
        end
    end

    // ========================================================
    // Done flag and interrupts; a set beats a same-cycle clear
    wire [1:0] irq_ev = {abort, done_ev};
    always_ff @(posedge core_clk_in or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            done_q              <= 1'b0;
            print_done_flag_out <= 1'b0;
            irq_stat_q          <= print_seq_pkg::IRQ_RST;
            irq_out             <= 1'b0;
        end
        else
        begin
            if (done_ev)
                done_q <= 1'b1;
            else if (start)
                done_q <= 1'b0;
            print_done_flag_out <= done_ev | (done_q & ~start);
            irq_stat_q <= irq_ev
                        | (irq_stat_q & ~(wr_clr ? hwdata_in[1:0] : 2'h0));
            irq_out    <= |((irq_ev | irq_stat_q
                        & ~(wr_clr ? hwdata_in[1:0] : 2'h0)) & irq_en_q);
        end
    end
endmodule : ascii_string_output_sequencer
`default_nettype wire

/* File: tb/print_seq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Output point checker
module print_seq_checker (
    // Clock, reset and bus answer
    input wire logic       core_clk_in,
    input wire logic       rst_b_in,
    input wire logic       hreadyout_out,
    input wire logic       hresp_out,
    // Drive pin and output points
    input wire logic       drive_contact_in,
    input wire logic [7:0] ascii_print_output_out,
    input wire logic       scan_strobe_point_out,
    input wire logic       execution_active_point_out,
    input wire logic       print_done_flag_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus answer not ready or not okay");
    strobe_in_run_a: assert property (
        scan_strobe_point_out |-> execution_active_point_out)
        else $error("strobe outside a string");
    data_held_a: assert property (
        scan_strobe_point_out |-> $stable(ascii_print_output_out))
        else $error("data moved under the strobe");
    idle_data_zero_a: assert property (
        !execution_active_point_out |-> ascii_print_output_out == 8'h00)
        else $error("data points left on outside a string");
    setup_first_a: assert property (
        $rose(execution_active_point_out) |-> !scan_strobe_point_out)
        else $error("string began with the strobe high");
    done_not_run_a: assert property (
        print_done_flag_out |-> !execution_active_point_out)
        else $error("done flag high during a string");
    // Synchroniser is four flops, so six held cycles cover it
    held_no_done_a: assert property (
        drive_contact_in [*6] |=> !$rose(print_done_flag_out))
        else $error("done flag rose while drive held");
    done_fall_start_a: assert property (
        $fell(print_done_flag_out) |-> ##[0:2] execution_active_point_out)
        else $error("done flag cleared without a new string");

    cover property ($rose(print_done_flag_out));
    cover property ($fell(drive_contact_in) && execution_active_point_out);
    cover property ($rose(scan_strobe_point_out));
endmodule : print_seq_checker

bind ascii_string_output_sequencer print_seq_checker i_print_seq_checker (
    .core_clk_in               (core_clk_in),
    .rst_b_in                  (rst_b_in),
    .hreadyout_out             (hreadyout_out),
    .hresp_out                 (hresp_out),
    .drive_contact_in          (drive_contact_in),
    .ascii_print_output_out    (ascii_print_output_out),
    .scan_strobe_point_out     (scan_strobe_point_out),
    .execution_active_point_out(execution_active_point_out),
    .print_done_flag_out       (print_done_flag_out)
);
`default_nettype wire

/* File: tb/print_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Character display input
module print_sink_model (
    // Clock and bench control
    input  wire logic       core_clk_in,
    input  wire logic       clear_in,
    input  wire logic [3:0] idx_in,
    // Output points
    input  wire logic [7:0] char_in,
    input  wire logic       strobe_in,
    // Captured text
    output logic      [4:0] count_out,
    output logic      [7:0] char_out
);
    logic [7:0] got_q [16];
    logic       strobe_q;

    assign char_out = got_q[idx_in];

    // Latch on the strobe rising edge; data must already be settled
    always_ff @(posedge core_clk_in)
    begin
        strobe_q <= strobe_in;
        if (clear_in)
            count_out <= 5'h00;
        else if (strobe_in && !strobe_q)
        begin
            got_q[count_out[3:0]] <= char_in;
            count_out <= count_out + 5'h01;
        end
    end
endmodule : print_sink_model
`default_nettype wire

/* File: tb/test_ascii_string_output_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Bench top
module test_ascii_string_output_sequencer;
    logic        core_clk_in, rst_b_in, hsel_in, hwrite_in;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic        hreadyout_out, hresp_out, drive_contact_in, irq_out;
    logic [7:0]  ascii_print_output_out, sink_char;
    logic        scan_strobe_point_out, execution_active_point_out;
    logic        print_done_flag_out, clear;
    logic [3:0]  idx;
    logic [4:0]  sink_count;
    logic [31:0] src [4];
    logic [15:0] rnd;
    int          num_errors, check_count, target;
    logic [7:0]  ra [8] = '{print_seq_pkg::CTRL_OFS,
        print_seq_pkg::PERIOD_OFS, print_seq_pkg::STATUS_OFS,
        print_seq_pkg::IRQ_STAT_OFS, print_seq_pkg::IRQ_CLR_OFS,
        print_seq_pkg::IRQ_EN_OFS, print_seq_pkg::SRC3_OFS, 8'h40};
    logic [31:0] re [8] = '{32'h0, {16'h0, print_seq_pkg::PERIOD_RST},
        32'h0, 32'h0, 32'h0, 32'h0, print_seq_pkg::SRC_RST, 32'h0};

    ascii_string_output_sequencer i_ascii_string_output_sequencer (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .drive_contact_in(drive_contact_in),
        .ascii_print_output_out(ascii_print_output_out),
        .scan_strobe_point_out(scan_strobe_point_out),
        .execution_active_point_out(execution_active_point_out),
        .print_done_flag_out(print_done_flag_out), .irq_out(irq_out));
    print_sink_model i_print_sink_model (
        .core_clk_in(core_clk_in), .clear_in(clear), .idx_in(idx),
        .char_in(ascii_print_output_out),
        .strobe_in(scan_strobe_point_out),
        .count_out(sink_count), .char_out(sink_char));

    // ==================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [7:0] exp_char(input logic [1:0] b, input int k);
        logic [31:0] w;
        w = src[2'(b + k / 4)];
        return w[8 * (k % 4) +: 8];
    endfunction : exp_char
    function automatic logic pick(input int sel);
        case (sel)
            0: return hreadyout_out;
            1: return execution_active_point_out;
            2: return print_done_flag_out;
            default: return sink_count >= 5'(target);
        endcase
    endfunction : pick
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Every wait is bounded; running out ends the run as a failure
    task automatic wait_on(input int sel, input logic lvl);
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk_in);
            k++;
        end while (pick(sel) !== lvl && k < 2000);
        if (k >= 2000)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_on
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        haddr_in <= {24'h0, a};
        hwrite_in <= w;
        htrans_in <= print_seq_pkg::HTRANS_NONSEQ;
        wait_on(0, 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_on(0, 1'b1);
        rd = hrdata_out;
    endtask : bus
    task automatic fill(input logic [1:0] b, input int p);
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            src[i] = {rnd, lfsr(rnd)} | 32'h0101_0101;
        end
        if (p < 16)
            src[2'(b + p / 4)][8 * (p % 4) +: 8] = 8'h00;
        for (int i = 0; i < 4; i++)
            bus(1'b1, print_seq_pkg::SRC0_OFS + 8'(4 * i), src[i]);
    endtask : fill
    // cut: strobes seen before the drive pin drops; above n it stays held
    task automatic run(input logic m, input logic [1:0] b, input int n,
                       input int cut);
        logic [1:0] en;
        logic [1:0] stat;
        logic       abort;
        abort = !m && cut < n;
        stat = abort ? 2'b10 : 2'b01;
        rnd = lfsr(rnd);
        en = rnd[1:0];
        bus(1'b1, print_seq_pkg::IRQ_EN_OFS, {30'h0, en});
        bus(1'b1, print_seq_pkg::CTRL_OFS, {26'h0, b, 2'b01, m, 1'b0});
        clear <= 1'b1;
        drive_contact_in <= 1'b1;
        wait_on(1, 1'b1);
        clear <= 1'b0;
        target = cut;
        if (cut <= n)
        begin
            wait_on(3, 1'b1);
            drive_contact_in <= 1'b0;
        end
        wait_on(1, 1'b0);
        if (abort)
            chk(32'(sink_count < 5'd8), 32'h1);
        else
            chk(32'(sink_count), 32'(n));
        for (int k = 0; k < n; k++)
        begin
            idx = 4'(k);
            #1;
            if (k < int'(sink_count))
                chk(32'(sink_char), 32'(exp_char(b, k)));
        end
        @(posedge core_clk_in);
        if (cut > n)
        begin
            bus(1'b0, print_seq_pkg::STATUS_OFS, 32'h0);
            // Held after a fixed string: busy, drive seen, index at last
            chk(32'({rd[11:0], print_done_flag_out}),
                32'({print_seq_pkg::FIXED_LAST, 9'h00c}));
            drive_contact_in <= 1'b0;
        end
        if (abort)
            chk(32'(print_done_flag_out), 32'h0);
        else
            wait_on(2, 1'b1);
        bus(1'b0, print_seq_pkg::IRQ_STAT_OFS, 32'h0);
        chk(32'(rd[1:0]), 32'(stat));
        chk(32'(irq_out), 32'((en & stat) != 2'b00));
        bus(1'b1, print_seq_pkg::IRQ_CLR_OFS, 32'h3);
        bus(1'b0, print_seq_pkg::IRQ_STAT_OFS, 32'h0);
        chk(32'({rd[1:0], irq_out}), 32'h0);
        $display("String test done, mode %0d, %0d chars", m, n);
    endtask : run

    // ==================================================
    // Clock and main sequence
    initial
    begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial
    begin
        int p;
        logic [1:0] b;
        {rst_b_in, hwrite_in, drive_contact_in, htrans_in} = 5'h0;
        {haddr_in, hwdata_in, idx, target} = 0;
        hsel_in = 1'b1;
        hsize_in = print_seq_pkg::HSIZE_WORD;
        clear = 1'b1;
        num_errors = 0;
        check_count = 0;
        rnd = 16'h918c;
        repeat (10) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, ra[i], 32'h0);
            chk(rd, re[i]);
        end
        $display("Register reset test done");
        bus(1'b1, print_seq_pkg::PERIOD_OFS, 32'h2);
        fill(2'd0, 5);
        run(1'b0, 2'd0, 8, 99);
        run(1'b0, 2'd0, 8, 3);
        run(1'b0, 2'd0, 8, 99);
        for (int i = 0; i < 3; i++)
        begin
            rnd = lfsr(rnd);
            b = rnd[5:4];
            p = i == 0 ? 1 : i == 1 ? 2 + int'(rnd[3:0]) % 13 : 16;
            fill(b, p);
            run(1'b1, b, p, 0);
        end
        report_and_stop();
    end
endmodule : test_ascii_string_output_sequencer
`default_nettype wire
